// ---- include/i2c_port_params.svh ----
`ifndef I2C_PORT_PARAMS_SVH
`define I2C_PORT_PARAMS_SVH

`define SLAVE_ADDR_DEF 7'h32
`define REG_DEPTH 64
`define PTR_RESET 8'h00
`define PAGE_FIRST 4'h1
`define PAGE_LAST 4'h3
`define PAGE_END_NIB 4'hF
`define TIMEOUT_NS 950_000_000
`define LINK_PERIOD_NS 32
`define TIMEOUT_CYC ((`TIMEOUT_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)
`define REF_PERIOD_NS 5
`define SCL_PERIOD_NS 10_000
`define QTR_CYC (`SCL_PERIOD_NS / (4 * `REF_PERIOD_NS))
`define BYTE_BITS 4'h8

`endif

// ---- include/i2c_port_pkg.sv ----
package i2c_port_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WACK,
        S_RDATA, S_MACK, S_IGNORE
    } dev_state_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} host_state_t;
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} host_op_t;
endpackage

// ---- include/i2c_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
    logic sclHostOe;
    logic sclHostOut;
    logic sdaHostOe;
    logic sdaHostOut;
    logic sdaDevOe;
    logic sdaDevOut;
    wire logic scl;
    wire logic sda;
    // Wired-AND: a line is low when any enabled driver drives low.
    assign scl = ~(sclHostOe & ~sclHostOut);
    assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
    modport dev (input scl, input sda, output sdaDevOe, output sdaDevOut);
    modport host (input scl, input sda, output sclHostOe, output sclHostOut,
                  output sdaHostOe, output sdaHostOut);
endinterface
`default_nettype wire

// ---- design/i2c_slave_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_params.svh"
module i2c_slave_dev #(
    parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF,
    parameter int TIMEOUT_CYC = `TIMEOUT_CYC,
    parameter int DEPTH = `REG_DEPTH
) (
    // Link side
    input wire logic linkClk,
    i2c_link_if.dev bus,
    // User side
    input wire logic ref_clk,
    input wire logic arst_n,
    output logic holdCarry,
    output logic wrPulse,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData
);
    import i2c_port_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    if (DEPTH < 64 || DEPTH > 256 || (1 << IDX_W) != DEPTH) begin
        $error("DEPTH must be a power of two from 64 to 256");
    end
    if (TIMEOUT_CYC < 2) begin
        $error("TIMEOUT_CYC too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer increment with page wrap.
    function automatic logic [7:0] nextPtr(input logic [7:0] p);
        logic inPage;
        inPage = (p[7:4] >= `PAGE_FIRST) && (p[7:4] <= `PAGE_LAST);
        if (inPage && p[3:0] == `PAGE_END_NIB) begin
            nextPtr = {p[7:4], 4'h0};
        end else begin
            nextPtr = p + 8'h01;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link domain.
    logic sclS1_q, sclS2_q, sclPrev_q;
    logic sdaS1_q, sdaS2_q, sdaPrev_q;
    dev_state_t state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shIn_q;
    logic [7:0] shOut_q;
    logic [7:0] ptr_q;
    logic rdDir_q;
    logic sdaOe_q;
    logic open_q;
    logic [31:0] toCnt_q;
    logic lnkWrTgl_q;
    logic [7:0] lnkWrAddr_q;
    logic [7:0] lnkWrData_q;
    logic [7:0] mem [DEPTH];

    wire logic startSeen = sclS2_q & sclPrev_q & sdaPrev_q & ~sdaS2_q;
    wire logic stopSeen = sclS2_q & sclPrev_q & ~sdaPrev_q & sdaS2_q;
    wire logic sclRise = sclS2_q & ~sclPrev_q;
    wire logic sclFall = ~sclS2_q & sclPrev_q;
    wire logic byteDone = (bitCnt_q == `BYTE_BITS);
    wire logic addrMatch = (shIn_q[7:1] == SLAVE_ADDR);
    wire logic timeoutHit = open_q && (toCnt_q >= 32'(TIMEOUT_CYC - 1));
    wire logic [7:0] memAtPtr = mem[ptr_q[IDX_W-1:0]];

    assign bus.sdaDevOe = sdaOe_q;
    assign bus.sdaDevOut = 1'b0;

    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            sclS1_q <= 1'b1;
            sclS2_q <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaS1_q <= 1'b1;
            sdaS2_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclS1_q <= bus.scl;
            sclS2_q <= sclS1_q;
            sclPrev_q <= sclS2_q;
            sdaS1_q <= bus.sda;
            sdaS2_q <= sdaS1_q;
            sdaPrev_q <= sdaS2_q;
        end
    end

    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            toCnt_q <= 32'h0000_0000;
            open_q <= 1'b0;
        end else if (timeoutHit || stopSeen) begin
            toCnt_q <= 32'h0000_0000;
            open_q <= 1'b0;
        end else if (startSeen && !open_q) begin
            toCnt_q <= 32'h0000_0000;
            open_q <= 1'b1;
        end else if (open_q) begin
            toCnt_q <= toCnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge linkClk) begin
        if (sclFall && state_q == S_WDATA && byteDone) begin
            mem[ptr_q[IDX_W-1:0]] <= shIn_q;
        end
    end

    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            bitCnt_q <= 4'h0;
            shIn_q <= 8'h00;
            shOut_q <= 8'h00;
            ptr_q <= `PTR_RESET;
            rdDir_q <= 1'b0;
            sdaOe_q <= 1'b0;
            lnkWrTgl_q <= 1'b0;
            lnkWrAddr_q <= 8'h00;
            lnkWrData_q <= 8'h00;
        end else if (timeoutHit) begin
            state_q <= S_IDLE;
            sdaOe_q <= 1'b0;
        end else if (startSeen) begin
            state_q <= S_ADDR;
            bitCnt_q <= 4'h0;
            sdaOe_q <= 1'b0;
        end else if (stopSeen) begin
            state_q <= S_IDLE;
            sdaOe_q <= 1'b0;
        end else begin
            if (sclRise && state_q != S_IDLE) begin
                shIn_q <= {shIn_q[6:0], sdaS2_q};
                bitCnt_q <= bitCnt_q + 4'h1;
            end
            if (sclFall) begin
                case (state_q)
                    S_ADDR: begin
                        if (byteDone) begin
                            if (addrMatch) begin
                                state_q <= S_ADDR_ACK;
                                sdaOe_q <= 1'b1;
                                rdDir_q <= shIn_q[0];
                            end else begin
                                state_q <= S_IGNORE;
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        bitCnt_q <= 4'h0;
                        if (rdDir_q) begin
                            state_q <= S_RDATA;
                            shOut_q <= memAtPtr;
                            sdaOe_q <= ~memAtPtr[7];
                        end else begin
                            state_q <= S_PTR;
                            sdaOe_q <= 1'b0;
                        end
                    end
                    S_PTR: begin
                        if (byteDone) begin
                            ptr_q <= shIn_q;
                            state_q <= S_PTR_ACK;
                            sdaOe_q <= 1'b1;
                        end
                    end
                    S_WDATA: begin
                        if (byteDone) begin
                            ptr_q <= nextPtr(ptr_q);
                            lnkWrTgl_q <= ~lnkWrTgl_q;
                            lnkWrAddr_q <= ptr_q;
                            lnkWrData_q <= shIn_q;
                            state_q <= S_WACK;
                            sdaOe_q <= 1'b1;
                        end
                    end
                    S_PTR_ACK, S_WACK: begin
                        bitCnt_q <= 4'h0;
                        sdaOe_q <= 1'b0;
                        state_q <= S_WDATA;
                    end
                    S_RDATA: begin
                        if (byteDone) begin
                            sdaOe_q <= 1'b0;
                            ptr_q <= nextPtr(ptr_q);
                            state_q <= S_MACK;
                        end else begin
                            shOut_q <= {shOut_q[6:0], 1'b0};
                            sdaOe_q <= ~shOut_q[6];
                        end
                    end
                    S_MACK: begin
                        bitCnt_q <= 4'h0;
                        if (!shIn_q[0]) begin
                            state_q <= S_RDATA;
                            shOut_q <= memAtPtr;
                            sdaOe_q <= ~memAtPtr[7];
                        end else begin
                            state_q <= S_IGNORE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference domain. The write event crosses as a toggle; address and
    // data are stable for at least nine bit times after it flips, far
    // longer than the three-flop delay, so they are captured directly.
    logic openS1_q, openS2_q;
    logic tglS1_q, tglS2_q, tglPrev_q;
    logic holdCarry_q, wrPulse_q;
    logic [7:0] wrAddr_q, wrData_q;

    wire logic wrSeen = tglS2_q ^ tglPrev_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            openS1_q <= 1'b0;
            openS2_q <= 1'b0;
            tglS1_q <= 1'b0;
            tglS2_q <= 1'b0;
            tglPrev_q <= 1'b0;
            holdCarry_q <= 1'b0;
            wrPulse_q <= 1'b0;
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
        end else begin
            openS1_q <= open_q;
            openS2_q <= openS1_q;
            holdCarry_q <= openS2_q;
            tglS1_q <= lnkWrTgl_q;
            tglS2_q <= tglS1_q;
            tglPrev_q <= tglS2_q;
            wrPulse_q <= wrSeen;
            if (wrSeen) begin
                wrAddr_q <= lnkWrAddr_q;
                wrData_q <= lnkWrData_q;
            end
        end
    end

    assign holdCarry = holdCarry_q;
    assign wrPulse = wrPulse_q;
    assign wrAddr = wrAddr_q;
    assign wrData = wrData_q;
endmodule
`default_nettype wire

// ---- design/i2c_master_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_params.svh"
module i2c_master_host #(
    parameter int QTR_CYC = `QTR_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link side
    i2c_link_if.host bus,
    // Command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire i2c_port_pkg::host_op_t cmdOp,
    input wire logic [7:0] cmdData,
    input wire logic cmdAck,
    // Response
    output logic rspValid,
    output logic [7:0] rspData,
    output logic rspAck
);
    import i2c_port_pkg::*;

    // The sample point is a quarter before the clock falls and lags the line by two
    // synchroniser cycles, so the synchroniser needs a quarter of at least four cycles.
    if (QTR_CYC < 4 || QTR_CYC > 65536) begin
        $error("QTR_CYC must be from 4 to 65536");
    end

    ////////////////////////////////////////////////////////////////////////
    host_state_t state_q;
    logic [15:0] qCnt_q;
    logic [1:0] quarter_q;
    logic [3:0] bitIdx_q;
    logic [8:0] shTx_q, shRx_q;
    logic sclOe_q, sdaOe_q;
    logic sdaS1_q, sdaS2_q;
    logic cmdReady_q, rspValid_q, rspAck_q;
    logic [7:0] rspData_q;

    wire logic tick = (qCnt_q == 16'(QTR_CYC - 1));
    wire logic take = cmdValid && cmdReady_q && state_q == H_IDLE;
    wire logic lastQ = tick && quarter_q == 2'h3;
    wire logic lastBit = (bitIdx_q == `BYTE_BITS);

    assign bus.sclHostOe = sclOe_q;
    assign bus.sclHostOut = 1'b0;
    assign bus.sdaHostOe = sdaOe_q;
    assign bus.sdaHostOut = 1'b0;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdaS1_q <= 1'b1;
            sdaS2_q <= 1'b1;
            qCnt_q <= 16'h0000;
            quarter_q <= 2'h0;
        end else begin
            sdaS1_q <= bus.sda;
            sdaS2_q <= sdaS1_q;
            if (state_q == H_IDLE || tick) begin
                qCnt_q <= 16'h0000;
            end else begin
                qCnt_q <= qCnt_q + 16'h0001;
            end
            if (state_q == H_IDLE) begin
                quarter_q <= 2'h0;
            end else if (tick) begin
                quarter_q <= quarter_q + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= H_IDLE;
            bitIdx_q <= 4'h0;
            shTx_q <= 9'h1FF;
            shRx_q <= 9'h000;
            sclOe_q <= 1'b0;
            sdaOe_q <= 1'b0;
            cmdReady_q <= 1'b1;
            rspValid_q <= 1'b0;
            rspAck_q <= 1'b0;
            rspData_q <= 8'h00;
        end else begin
            rspValid_q <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (take) begin
                        cmdReady_q <= 1'b0;
                        bitIdx_q <= 4'h0;
                        case (cmdOp)
                            OP_START: state_q <= H_START;
                            OP_STOP: state_q <= H_STOP;
                            OP_WRITE: begin
                                state_q <= H_BIT;
                                shTx_q <= {cmdData, 1'b1};
                            end
                            default: begin
                                state_q <= H_BIT;
                                shTx_q <= {8'hFF, ~cmdAck};
                            end
                        endcase
                    end
                end
                H_START: begin
                    if (tick) begin
                        case (quarter_q)
                            2'h0: sdaOe_q <= 1'b0;
                            2'h1: sclOe_q <= 1'b0;
                            2'h2: sdaOe_q <= 1'b1;
                            default: begin
                                sclOe_q <= 1'b1;
                                state_q <= H_IDLE;
                                cmdReady_q <= 1'b1;
                            end
                        endcase
                    end
                end
                H_STOP: begin
                    if (tick) begin
                        case (quarter_q)
                            2'h0: sdaOe_q <= 1'b1;
                            2'h1: sclOe_q <= 1'b0;
                            2'h2: sdaOe_q <= 1'b0;
                            default: begin
                                state_q <= H_IDLE;
                                cmdReady_q <= 1'b1;
                            end
                        endcase
                    end
                end
                H_BIT: begin
                    if (tick) begin
                        case (quarter_q)
                            2'h0: sdaOe_q <= ~shTx_q[8];
                            2'h1: sclOe_q <= 1'b0;
                            2'h2: shRx_q <= {shRx_q[7:0], sdaS2_q};
                            default: begin
                                sclOe_q <= 1'b1;
                                shTx_q <= {shTx_q[7:0], 1'b1};
                                bitIdx_q <= bitIdx_q + 4'h1;
                            end
                        endcase
                    end
                    if (lastQ && lastBit) begin
                        state_q <= H_IDLE;
                        cmdReady_q <= 1'b1;
                        rspValid_q <= 1'b1;
                        rspData_q <= shRx_q[8:1];
                        rspAck_q <= ~shRx_q[0];
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign cmdReady = cmdReady_q;
    assign rspValid = rspValid_q;
    assign rspData = rspData_q;
    assign rspAck = rspAck_q;
endmodule
`default_nettype wire

// ---- tb/i2c_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_link_checker #(
    parameter logic [6:0] SLAVE_ADDR = 7'h32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link lines
    input wire logic scl,
    input wire logic sda,
    input wire logic sclHostOe,
    input wire logic sclHostOut,
    input wire logic sdaHostOe,
    input wire logic sdaHostOut,
    input wire logic sdaDevOe,
    input wire logic sdaDevOut
);
    // The fast clock oversamples both parties, so bus edges are judged here.
    logic sclQ, sdaQ, openQ, addrQ, wrQ;
    logic [3:0] cntQ;
    logic [7:0] shQ;
    wire logic startC = sclQ & scl & sdaQ & ~sda;
    wire logic stopC = sclQ & scl & ~sdaQ & sda;
    wire logic riseC = scl & ~sclQ & openQ;
    wire logic hitC = (shQ[7:1] == SLAVE_ADDR);
    wire logic ninthC = riseC & (cntQ == 4'h8);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            openQ <= 1'b0;
            addrQ <= 1'b0;
            wrQ <= 1'b0;
            cntQ <= 4'h0;
            shQ <= 8'h00;
        end else begin
            sclQ <= scl;
            sdaQ <= sda;
            openQ <= startC | (openQ & ~stopC);
            addrQ <= startC | (addrQ & ~stopC & ~ninthC);
            wrQ <= ~startC & ~stopC & ((ninthC & addrQ) ? (hitC & ~shQ[0]) : wrQ);
            cntQ <= startC ? 4'h0 : (riseC ? ((cntQ == 4'h9) ? 4'h1 : cntQ + 4'h1) : cntQ);
            shQ <= (riseC & (cntQ != 4'h8)) ? {shQ[6:0], sda} : shQ;
        end
    end
    //////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_dev_low;
        sdaDevOe |-> !sdaDevOut;
    endproperty
    a_dev_low: assert property (p_dev_low) else $error("device drives data high");
    property p_host_sda_low;
        sdaHostOe |-> !sdaHostOut;
    endproperty
    a_host_sda_low: assert property (p_host_sda_low) else $error("host drives data high");
    property p_host_scl_low;
        sclHostOe |-> !sclHostOut;
    endproperty
    a_host_scl_low: assert property (p_host_scl_low) else $error("host drives clock high");
    property p_idle_high;
        !openQ && !startC |-> scl && sda;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle bus not high");
    property p_dev_quiet_idle;
        !openQ |-> !sdaDevOe;
    endproperty
    a_dev_quiet_idle: assert property (p_dev_quiet_idle) else $error("device busy after stop");
    property p_dev_quiet_addr;
        addrQ && cntQ < 4'h8 |-> !sdaDevOe;
    endproperty
    a_dev_quiet_addr: assert property (p_dev_quiet_addr) else $error("device drives in address");
    property p_dev_stable_high;
        scl && sclQ |-> $stable(sdaDevOe);
    endproperty
    a_dev_stable_high: assert property (p_dev_stable_high) else $error("device data moves");
    property p_addr_ack;
        ninthC && addrQ |-> sda == !hitC;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("wrong address answer");
    property p_write_ack;
        ninthC && wrQ && !addrQ |-> !sda;
    endproperty
    a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_params.svh"
module testbench;
    import i2c_port_pkg::*;
    localparam int QTR = 30;
    // Kept short for run time; every transaction here but the one left open ends well inside it.
    localparam int TO_CYC = 2500;
    localparam logic [6:0] SA = `SLAVE_ADDR_DEF;
    logic ref_clk, linkClk, arst_n, cmdValid, cmdAck;
    host_op_t cmdOp;
    logic [7:0] cmdData;
    wire logic cmdReady, rspValid, rspAck, holdCarry, wrPulse;
    wire logic [7:0] rspData, wrAddr, wrData;
    int numErrors = 0;
    int compares = 0;
    int mem [64];
    int ptr = 0;
    logic [15:0] rnd = 16'h69EF;
    logic [15:0] expWr [$];
    logic [15:0] seenWr [$];
    i2c_link_if link ();
    i2c_slave_dev #(.SLAVE_ADDR(SA), .TIMEOUT_CYC(TO_CYC)) i_i2c_slave_dev (
        .linkClk(linkClk), .bus(link.dev), .ref_clk(ref_clk), .arst_n(arst_n),
        .holdCarry(holdCarry), .wrPulse(wrPulse), .wrAddr(wrAddr), .wrData(wrData));
    i2c_master_host #(.QTR_CYC(QTR)) i_i2c_master_host (
        .ref_clk(ref_clk), .arst_n(arst_n), .bus(link.host), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdData(cmdData), .cmdAck(cmdAck),
        .rspValid(rspValid), .rspData(rspData), .rspAck(rspAck));
    i2c_link_checker #(.SLAVE_ADDR(SA)) i_i2c_link_checker (
        .ref_clk(ref_clk), .arst_n(arst_n), .scl(link.scl), .sda(link.sda),
        .sclHostOe(link.sclHostOe), .sclHostOut(link.sclHostOut), .sdaHostOe(link.sdaHostOe),
        .sdaHostOut(link.sdaHostOut), .sdaDevOe(link.sdaDevOe), .sdaDevOut(link.sdaDevOut));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        linkClk = 1'b0;
        #3.7;
        forever #16 linkClk = ~linkClk;
    end
    always @(negedge ref_clk) begin
        if (wrPulse === 1'b1) begin
            seenWr.push_back({wrAddr, wrData});
        end
    end
    //////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return s[0] ? ((s >> 1) ^ 16'hB400) : (s >> 1);
    endfunction
    function automatic int nextPtr(input int p);
        return (p % 16 == 15 && p > 15 && p < 64) ? p - 15 : p + 1;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic hostOp(input host_op_t op, input logic [7:0] d, input logic a);
        int n;
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdData <= d;
        cmdAck <= a;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        n = 0;
        repeat (2) @(negedge ref_clk);
        while (cmdReady !== 1'b1 && n < 40 * QTR) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 40 * QTR) begin
            numErrors++;
            printVerdict();
        end
        check("rsp valid", {15'h0, rspValid}, {15'h0, op == OP_WRITE || op == OP_READ});
    endtask
    task automatic stopOp();
        hostOp(OP_STOP, 8'h00, 1'b0);
    endtask
    task automatic putByte(input logic [7:0] d, input logic ack);
        hostOp(OP_WRITE, d, 1'b0);
        check("byte ack", {15'h0, rspAck}, {15'h0, ack});
        check("byte echo", {8'h00, rspData}, {8'h00, d});
    endtask
    task automatic setPtr(input int p);
        hostOp(OP_START, 8'h00, 1'b0);
        putByte({SA, 1'b0}, 1'b1);
        putByte(8'(p), 1'b1);
        ptr = p;
    endtask
    task automatic openRead();
        hostOp(OP_START, 8'h00, 1'b0);
        putByte({SA, 1'b1}, 1'b1);
    endtask
    task automatic putData(input logic [7:0] d);
        putByte(d, 1'b1);
        mem[ptr] = d;
        expWr.push_back({8'(ptr), d});
        ptr = nextPtr(ptr);
    endtask
    task automatic getData(input logic a);
        hostOp(OP_READ, 8'h00, a);
        check("read byte", {8'h00, rspData}, 16'(mem[ptr]));
        ptr = nextPtr(ptr);
    endtask
    task automatic cmpWr();
        check("store count", 16'(seenWr.size()), 16'(expWr.size()));
        while (seenWr.size() > 0 && expWr.size() > 0) begin
            check("store", seenWr.pop_front(), expWr.pop_front());
        end
        seenWr.delete();
        expWr.delete();
    endtask
    //////////////////////////////////////////////////
    initial begin
        int n;
        arst_n = 1'b0;
        cmdValid = 1'b0;
        cmdOp = OP_START;
        cmdData = 8'h00;
        cmdAck = 1'b0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        hostOp(OP_START, 8'h00, 1'b0);
        putByte({SA ^ 7'h01, 1'b0}, 1'b0);
        putByte(8'h10, 1'b0);
        stopOp();
        cmpWr();
        // Start each run at the page top so that the wrap is crossed every time.
        for (int pg = 1; pg < 4; pg++) begin
            setPtr(pg * 16 + 15);
            check("carry hold", {15'h0, holdCarry}, 16'h1);
            repeat (4) begin
                rnd = lfsr(rnd);
                putData(rnd[7:0]);
            end
            stopOp();
            repeat (20) @(negedge ref_clk);
            check("carry free", {15'h0, holdCarry}, 16'h0);
            cmpWr();
            setPtr(pg * 16 + 15);
            openRead();
            getData(1'b1);
            getData(1'b0);
            stopOp();
            openRead();
            getData(1'b0);
            stopOp();
        end
        // A transaction left open is abandoned and the data line let go.
        openRead();
        n = 0;
        while (holdCarry !== 1'b0 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 20000) begin
            numErrors++;
            printVerdict();
        end
        check("timeout late", {15'h0, n > 14000}, 16'h1);
        hostOp(OP_READ, 8'h00, 1'b0);
        check("after timeout", {8'h00, rspData}, 16'h00FF);
        stopOp();
        printVerdict();
    end
endmodule
`default_nettype wire
